// ### ssm_defines.svh
// constants of the supply supervisor and monitor logic
// assumes inclusion by ssm_pkg, ssm_top and the test bench
// ---------------------------------------------------------------
// Behaviour
// - high supervisor reset enable comes up set after reset
// - supervisors use two thresholds with hysteresis, monitors use one
// - external supply low sets sticky supervisor flag, may request reset
// - external supply under monitor level sets flag, may interrupt
// - high monitor resets under its level when level reset enable set and overvoltage clear
// - external supply rising past monitor level sets level-reached flag
// - high overvoltage reset works only at core level three
// - high changes mask events for a settling delay, then flag done
// - high supervisor flag in deep sleep only with sleep mode bit
// - all flags stay set until brownout reset or software clear
// - real-time clock and oscillator writes blocked while high supervisor off
// - all four units enabled at reset, each disabled by its own bit
// - core supply low sets sticky supervisor flag, may request reset
// - core supply under monitor level sets flag, may interrupt
// - low monitor resets on flag or on overvoltage per enables
// - core supply rising past monitor level sets level-reached flag
// - low changes mask events for a settling delay, then flag done
// - low supervisor flag in deep sleep only with sleep mode bit
// - power-up reset held until both supervisor release levels met
// - supervisors act by reset, monitors by flags and, with their reset enables, by reset
// - core level field resets to its lowest value
// ---------------------------------------------------------------
`ifndef SSM_DEFINES_SVH
`define SSM_DEFINES_SVH
// register byte offsets
`define SSM_OFF_CTRL_HI 5'h00
`define SSM_OFF_CTRL_LO 5'h04
`define SSM_OFF_CORE 5'h08
`define SSM_OFF_FLAGS 5'h0C
`define SSM_OFF_IE 5'h10
`define SSM_OFF_STATUS 5'h14
// side control fields
`define SSM_SUP_EN 0
`define SSM_MON_EN 1
`define SSM_ASSERT_LSB 2
`define SSM_RELEASE_LSB 4
`define SSM_SUP_RST 7
`define SSM_LVL_RST 8
`define SSM_OV_RST 9
`define SSM_SLEEP_MODE 10
`define SSM_EVT_MASK 11
`define SSM_CTRL_RST 12'h083
`define SSM_CHANGE_MASK 12'h07F
`define SSM_CORE_RST 2'h0
// flag and enable bits within one side, side stride
`define SSM_F_SUP 0
`define SSM_F_MON 1
`define SSM_F_LVL 2
`define SSM_F_DLY 3
`define SSM_SIDE_BITS 4
// status bits
`define SSM_ST_ILLEGAL 2
`define SSM_ST_POR 3
// settling delay
`define SSM_SETTLE_NS 1000
`define SSM_CLK_MHZ 100
`define SSM_SETTLE_CYC ((`SSM_SETTLE_NS * `SSM_CLK_MHZ + 999) / 1000)
`endif

// ### ssm_pkg.sv
// types of the supply supervisor and monitor logic
// assumes ssm_defines.svh on the include path
package ssm_pkg;
  `include "ssm_defines.svh"
  typedef logic [11:0] ssm_ctrl_t;
  typedef logic [7:0] ssm_count_t;
  typedef logic [31:0] ssm_word_t;
endpackage

// ### ssm_top.sv
// supervisor and monitor control, flags and reset request
// assumes asynchronous comparator outputs and an avalon-mm master
`timescale 1ns/1ns
`include "ssm_defines.svh"
module ssm_top
  import ssm_pkg::*;
(
  // clock and brownout reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // avalon-mm slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // external supply comparators, asynchronous
  input wire logic i_hi_below_assert,
  input wire logic i_hi_above_release,
  input wire logic i_hi_below_mon,
  input wire logic i_hi_over,
  // core supply comparators, asynchronous
  input wire logic i_lo_below_assert,
  input wire logic i_lo_above_release,
  input wire logic i_lo_below_mon,
  input wire logic i_lo_over,
  // cpu in sleep mode two, three or four
  input wire logic i_sleep_deep,
  // analogue settings
  output logic [1:0] o_core_level_select,
  output logic [1:0] o_hi_assert_threshold,
  output logic [2:0] o_hi_release_threshold,
  output logic [1:0] o_lo_assert_threshold,
  output logic [2:0] o_lo_release_threshold,
  output logic o_hi_sup_enable,
  output logic o_hi_mon_enable,
  output logic o_lo_sup_enable,
  output logic o_lo_mon_enable,
  // system effects
  output logic o_por_req,
  output logic o_irq,
  output logic o_rtc_write_block,
  output logic o_thresh_illegal
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0] meta_reg;
  logic [7:0] meta_next;
  logic [7:0] sync_reg;
  logic [7:0] sync_next;
  ssm_ctrl_t ctrl_reg [2];
  ssm_ctrl_t ctrl_next [2];
  ssm_count_t dly_reg [2];
  ssm_count_t dly_next [2];
  logic [1:0] core_reg;
  logic [1:0] core_next;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] ie_reg;
  logic [7:0] ie_next;
  logic [1:0] low_reg;
  logic [1:0] low_next;
  logic [1:0] above_reg;
  logic [1:0] above_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic por_reg;
  logic por_next;
  logic irq_reg;
  logic irq_next;
  logic illegal_reg;
  logic illegal_next;
  logic wr_hit;
  logic [15:0] lane_mask;
  logic [7:0] flag_clr;
  logic [7:0] set_vec;
  logic [1:0] por_vec;
  logic [1:0] trig_vec;

  // ---------------------------------------------------------------
  // comparator synchronisers
  // ---------------------------------------------------------------
  // first stage is read only by the second stage
  always_comb begin
    meta_next = {i_lo_over, i_lo_below_mon, i_lo_above_release,
                 i_lo_below_assert, i_hi_over, i_hi_below_mon,
                 i_hi_above_release, i_hi_below_assert};
    sync_next = meta_reg;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_reg <= 8'h00;
      sync_reg <= 8'h00;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // a write lands only at the edge where waitrequest is low
  assign wr_hit = i_avs_write & ack_reg;
  assign lane_mask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  assign flag_clr = (wr_hit && i_avs_address == `SSM_OFF_FLAGS) ?
                    (i_avs_writedata[7:0] & lane_mask[7:0]) : 8'h00;

  // ---------------------------------------------------------------
  // per-side event logic
  // ---------------------------------------------------------------
  for (genvar s = 0; s < 2; s++) begin : g_side
    logic [3:0] cmp;
    ssm_ctrl_t c;
    ssm_ctrl_t wr_val;
    logic wr_ctrl;
    logic live;
    logic sup_on;
    logic mon_on;
    logic ov_ok;
    logic [4:0] off;
    assign off = s ? `SSM_OFF_CTRL_LO : `SSM_OFF_CTRL_HI;
    assign cmp = sync_reg[4*s+3:4*s];
    assign c = ctrl_reg[s];
    assign wr_ctrl = wr_hit && i_avs_address == off;
    assign wr_val = (c & ~lane_mask[11:0]) |
                    (i_avs_writedata[11:0] & lane_mask[11:0]);
    // setting change restarts the settling delay
    assign trig_vec[s] = wr_ctrl &&
                         ((wr_val ^ c) & `SSM_CHANGE_MASK) != 12'h000;
    // events pass only when unmasked and settled
    assign live = !c[`SSM_EVT_MASK] && dly_reg[s] == 8'h00;
    assign sup_on = c[`SSM_SUP_EN];
    assign mon_on = c[`SSM_MON_EN];
    // high-side overvoltage only meaningful at top core level
    assign ov_ok = (s == 1) || core_reg == 2'h3;

    always_comb begin
      set_vec[4*s+`SSM_F_SUP] = sup_on && live && low_reg[s] &&
                                (!i_sleep_deep || c[`SSM_SLEEP_MODE]);
      set_vec[4*s+`SSM_F_MON] = mon_on && live && cmp[2];
      // level reached on the rising crossing of the monitor level
      set_vec[4*s+`SSM_F_LVL] = mon_on && live && !cmp[2] &&
                                !above_reg[s];
      set_vec[4*s+`SSM_F_DLY] = dly_reg[s] == 8'h01 && !trig_vec[s];
      // supervisors reset; monitors reset only through their enables
      // event mask and settling delay hold back supervisor resets too
      por_vec[s] = (sup_on && c[`SSM_SUP_RST] && low_reg[s] &&
                    live) ||
                   (mon_on && live && c[`SSM_LVL_RST] && !c[`SSM_OV_RST] &&
                    cmp[2]) ||
                   (mon_on && live && c[`SSM_LVL_RST] && c[`SSM_OV_RST] &&
                    cmp[3] && ov_ok);
    end

    // control, delay and hysteresis next values
    always_comb begin
      ctrl_next[s] = wr_ctrl ? wr_val : c;
      if (trig_vec[s]) begin
        dly_next[s] = 8'(`SSM_SETTLE_CYC);
      end else if (dly_reg[s] != 8'h00) begin
        dly_next[s] = dly_reg[s] - 8'h01;
      end else begin
        dly_next[s] = 8'h00;
      end
      // falls below assert level, leaves only above release level
      if (cmp[0]) begin
        low_next[s] = 1'b1;
      end else if (cmp[1]) begin
        low_next[s] = 1'b0;
      end else begin
        low_next[s] = low_reg[s];
      end
      above_next[s] = !cmp[2];
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        ctrl_reg[s] <= `SSM_CTRL_RST;
        dly_reg[s] <= 8'h00;
        low_reg[s] <= 1'b1;
        above_reg[s] <= 1'b0;
      end else begin
        ctrl_reg[s] <= ctrl_next[s];
        dly_reg[s] <= dly_next[s];
        low_reg[s] <= low_next[s];
        above_reg[s] <= above_next[s];
      end
    end
  end

  // ---------------------------------------------------------------
  // core level, flags, enables
  // ---------------------------------------------------------------
  // set wins over a clear in the same cycle
  always_comb begin
    core_next = core_reg;
    ie_next = ie_reg;
    if (wr_hit && i_avs_address == `SSM_OFF_CORE && i_avs_byteenable[0]) begin
      core_next = i_avs_writedata[1:0];
    end
    if (wr_hit && i_avs_address == `SSM_OFF_IE && i_avs_byteenable[0]) begin
      ie_next = i_avs_writedata[7:0];
    end
    flags_next = (flags_reg & ~flag_clr) | set_vec;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      core_reg <= `SSM_CORE_RST;
      flags_reg <= 8'h00;
      ie_reg <= 8'h00;
    end else begin
      core_reg <= core_next;
      flags_reg <= flags_next;
      ie_reg <= ie_next;
    end
  end

  // ---------------------------------------------------------------
  // reset request, interrupt, code check
  // ---------------------------------------------------------------
  // supervisor flags carry no interrupt; they act by reset
  always_comb begin
    por_next = |por_vec;
    irq_next = |(flags_reg & ie_reg & 8'hEE);
    // release window is core..core+3, top level reaches code 7
    illegal_next = (ctrl_reg[0][6:4] < {1'b0, ctrl_reg[0][3:2]}) ||
                   (ctrl_reg[0][6:4] < {1'b0, core_reg}) ||
                   (core_reg != 2'h3 &&
                    ctrl_reg[0][6:4] > ({1'b0, core_reg} + 3'h3));
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      por_reg <= 1'b1;
      irq_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      por_reg <= por_next;
      irq_reg <= irq_next;
      illegal_reg <= illegal_next;
    end
  end

  // ---------------------------------------------------------------
  // bus handshake and read data
  // ---------------------------------------------------------------
  // one wait state: data is registered before waitrequest drops
  always_comb begin
    ack_next = (i_avs_read | i_avs_write) & ~ack_reg;
    rdata_next = rdata_reg;
    if (i_avs_read && !ack_reg) begin
      unique case (i_avs_address)
        `SSM_OFF_CTRL_HI: rdata_next = {20'h00000, ctrl_reg[0]};
        `SSM_OFF_CTRL_LO: rdata_next = {20'h00000, ctrl_reg[1]};
        `SSM_OFF_CORE: rdata_next = {30'h0000000, core_reg};
        `SSM_OFF_FLAGS: rdata_next = {24'h000000, flags_reg};
        `SSM_OFF_IE: rdata_next = {24'h000000, ie_reg};
        // delay status reads one while settling
        `SSM_OFF_STATUS: rdata_next = {28'h0000000, por_reg, illegal_reg,
                                       dly_reg[1] != 8'h00,
                                       dly_reg[0] != 8'h00};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
  assign o_avs_readdata = rdata_reg;
  assign o_core_level_select = core_reg;
  assign o_hi_assert_threshold = ctrl_reg[0][3:2];
  assign o_hi_release_threshold = ctrl_reg[0][6:4];
  assign o_lo_assert_threshold = ctrl_reg[1][3:2];
  assign o_lo_release_threshold = ctrl_reg[1][6:4];
  assign o_hi_sup_enable = ctrl_reg[0][`SSM_SUP_EN];
  assign o_hi_mon_enable = ctrl_reg[0][`SSM_MON_EN];
  assign o_lo_sup_enable = ctrl_reg[1][`SSM_SUP_EN];
  assign o_lo_mon_enable = ctrl_reg[1][`SSM_MON_EN];
  assign o_por_req = por_reg;
  assign o_irq = irq_reg;
  // protected clock registers need the high supervisor running
  assign o_rtc_write_block = ~ctrl_reg[0][`SSM_SUP_EN];
  assign o_thresh_illegal = illegal_reg;

endmodule

// ### ssm_top_asserts.sv
// checker for the supervisor and monitor block ports
// assumes it is bound to ssm_top
`timescale 1ns/1ns
module ssm_top_chk
  import ssm_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // bus
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic [31:0] o_avs_readdata,
  // settings and effects
  input wire logic [1:0] o_core_level_select,
  input wire logic [1:0] o_hi_assert_threshold,
  input wire logic [2:0] o_hi_release_threshold,
  input wire logic o_hi_sup_enable,
  input wire logic o_hi_mon_enable,
  input wire logic o_lo_sup_enable,
  input wire logic o_lo_mon_enable,
  input wire logic o_por_req,
  input wire logic o_rtc_write_block,
  input wire logic o_thresh_illegal
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  logic [2:0] core_x;
  logic bad;
  logic rd_go;
  // legal release window follows the core level
  assign core_x = {1'b0, o_core_level_select};
  assign bad = (o_hi_release_threshold < {1'b0, o_hi_assert_threshold}) || (o_hi_release_threshold < core_x)
    || (o_core_level_select != 2'h3 && o_hi_release_threshold > core_x + 3'h3);
  assign rd_go = i_avs_read & o_avs_waitrequest;
  // one request waiting, then its answer
  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_ack;
    !o_avs_waitrequest;
  endsequence
  a_one_wait: assert property (s_req |=> s_ack)
    else $error("waitrequest not released after one cycle");
  a_wait_first: assert property ($rose(i_avs_read) |-> o_avs_waitrequest)
    else $error("read answered without a wait state");
  a_idle_nowait: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
    else $error("waitrequest high while idle");
  a_data_hold: assert property ($changed(o_avs_readdata) |-> $past(rd_go))
    else $error("readdata changed outside a read");
  a_rtc_block: assert property (o_rtc_write_block == !o_hi_sup_enable)
    else $error("rtc write block does not follow supervisor enable");
  a_illegal_code: assert property ($stable({core_x, o_hi_assert_threshold, o_hi_release_threshold}) |-> o_thresh_illegal == bad)
    else $error("illegal threshold flag wrong");
  a_units_enabled: assert property ($rose(i_rst_b) |-> o_hi_sup_enable && o_hi_mon_enable && o_lo_sup_enable && o_lo_mon_enable)
    else $error("unit not enabled after reset");
  a_core_lowest: assert property ($rose(i_rst_b) |-> o_core_level_select == 2'h0 && o_hi_release_threshold == 3'h0)
    else $error("core level not lowest after reset");
  a_por_hold: assert property ($rose(i_rst_b) |-> o_por_req ##1 o_por_req)
    else $error("power-on reset released too early");
endmodule
bind ssm_top ssm_top_chk i_chk (.i_ref_clk, .i_rst_b, .i_avs_read, .i_avs_write, .o_avs_waitrequest,
  .o_avs_readdata, .o_core_level_select, .o_hi_assert_threshold, .o_hi_release_threshold,
  .o_hi_sup_enable, .o_hi_mon_enable, .o_lo_sup_enable, .o_lo_mon_enable, .o_por_req,
  .o_rtc_write_block, .o_thresh_illegal);

// ### ssm_supply_model.sv
// comparator model for one supply rail
// assumes a millivolt level from the bench and codes from the block
`timescale 1ns/1ns
module ssm_supply_model #(
  parameter int ASSERT_BASE = 1700,
  parameter int RELEASE_BASE = 1800,
  parameter int STEP = 100,
  parameter int OVER_MV = 3600
) (
  // codes and level
  input wire logic [1:0] i_assert_code,
  input wire logic [2:0] i_release_code,
  input wire logic [15:0] i_mv,
  // comparator outputs
  output logic o_below_assert,
  output logic o_above_release,
  output logic o_below_mon,
  output logic o_over
);
  // ---------------------------------------------------------------
  // thresholds
  // ---------------------------------------------------------------
  int thr_fall;
  int thr_rise;
  // two supervisor levels give hysteresis, monitor shares the rising one
  always_comb begin
    thr_fall = ASSERT_BASE + STEP * int'(i_assert_code);
    thr_rise = RELEASE_BASE + STEP * int'(i_release_code);
    o_below_assert = int'(i_mv) < thr_fall;
    o_above_release = int'(i_mv) > thr_rise;
    o_below_mon = int'(i_mv) < thr_rise;
    o_over = int'(i_mv) > OVER_MV;
  end
endmodule

// ### test_supply_supervisor_monitor_logic.sv
// self-checking bench for the supervisor and monitor block
// assumes ssm_pkg, the supply model and the checker are compiled first
`timescale 1ns/1ns
`include "ssm_defines.svh"
module test_supply_supervisor_monitor_logic
  import ssm_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic sleep = 1'b0;
  logic [4:0] addr = 5'h00;
  ssm_word_t wdata = 32'h0;
  ssm_word_t rdata;
  logic wait_req, por, irq, rtc_blk, illegal;
  logic [1:0] core, hi_ast, lo_ast, c, a;
  logic [2:0] hi_rel, lo_rel, r;
  logic [3:0] hi_cmp, lo_cmp, en;
  logic [15:0] hi_mv = 16'h0;
  logic [15:0] lo_mv = 16'h0;
  logic [15:0] nom[2] = '{16'h0BB8, 16'h0578};
  logic [15:0] dip[2] = '{16'h06D6, 16'h041A};
  logic [15:0] low[2] = '{16'h0640, 16'h0384};
  ssm_word_t exp_q[$], msk_q[$];
  string nm_q[$];
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [4:0] co;
  logic bad;

  ssm_supply_model i_hi (.i_assert_code(hi_ast), .i_release_code(hi_rel), .i_mv(hi_mv),
    .o_below_assert(hi_cmp[0]), .o_above_release(hi_cmp[1]), .o_below_mon(hi_cmp[2]), .o_over(hi_cmp[3]));
  ssm_supply_model #(.ASSERT_BASE(1000), .RELEASE_BASE(1100), .STEP(50), .OVER_MV(1600)) i_lo (
    .i_assert_code(lo_ast), .i_release_code(lo_rel), .i_mv(lo_mv),
    .o_below_assert(lo_cmp[0]), .o_above_release(lo_cmp[1]), .o_below_mon(lo_cmp[2]), .o_over(lo_cmp[3]));
  ssm_top i_dut (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .i_hi_below_assert(hi_cmp[0]), .i_hi_above_release(hi_cmp[1]),
    .i_hi_below_mon(hi_cmp[2]), .i_hi_over(hi_cmp[3]), .i_lo_below_assert(lo_cmp[0]),
    .i_lo_above_release(lo_cmp[1]), .i_lo_below_mon(lo_cmp[2]), .i_lo_over(lo_cmp[3]),
    .i_sleep_deep(sleep), .o_core_level_select(core), .o_hi_assert_threshold(hi_ast),
    .o_hi_release_threshold(hi_rel), .o_lo_assert_threshold(lo_ast), .o_lo_release_threshold(lo_rel),
    .o_hi_sup_enable(en[0]), .o_hi_mon_enable(en[1]), .o_lo_sup_enable(en[2]), .o_lo_mon_enable(en[3]),
    .o_por_req(por), .o_irq(irq), .o_rtc_write_block(rtc_blk), .o_thresh_illegal(illegal));

  // ---------------------------------------------------------------
  // clock, timeout, tasks
  // ---------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;
  // a hang counts as a mismatch
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input ssm_word_t seen, input ssm_word_t e, input string nm);
    n_tests++;
    if (seen !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic cb(input logic seen, input logic e, input string nm);
    chk({31'h0, seen}, {31'h0, e}, nm);
  endtask
  // request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] ad, input ssm_word_t d);
    @(posedge ref_clk);
    addr <= ad;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do @(posedge ref_clk); while (wait_req !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rdr(input logic [4:0] ad, input ssm_word_t m, input ssm_word_t e, input string nm);
    exp_q.push_back(e);
    msk_q.push_back(m);
    nm_q.push_back(nm);
    bus(1'b0, ad, 32'h0);
  endtask
  task automatic set_mv(input int s, input logic [15:0] v);
    @(posedge ref_clk);
    if (s == 0) hi_mv <= v;
    else lo_mv <= v;
  endtask
  // read results are checked against the oldest note
  always @(posedge ref_clk) begin
    if (rd && wait_req === 1'b0 && exp_q.size() > 0)
      chk(rdata & msk_q.pop_front(), exp_q.pop_front(), nm_q.pop_front());
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(41));
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    set_mv(0, nom[0]);
    repeat (10) @(posedge ref_clk);
    cb(por, 1'b1, "por one supply");
    set_mv(1, nom[1]);
    repeat (10) @(posedge ref_clk);
    cb(por, 1'b0, "por both supplies");
    chk({28'h0, en}, 32'hF, "unit enables");
    rdr(`SSM_OFF_CTRL_HI, 32'hFFFFFFFF, 32'h083, "ctrl hi");
    rdr(`SSM_OFF_CTRL_LO, 32'hFFFFFFFF, 32'h083, "ctrl lo");
    rdr(`SSM_OFF_CORE, 32'hFFFFFFFF, 32'h0, "core");
    rdr(5'h18, 32'hFFFFFFFF, 32'h0, "unmapped");
    bus(1'b1, `SSM_OFF_FLAGS, 32'hFF);
    rdr(`SSM_OFF_FLAGS, 32'hFF, 32'h0, "flags cleared");
    bus(1'b1, `SSM_OFF_IE, 32'hAA);
    for (int s = 0; s < 2; s++) begin
      co = s ? `SSM_OFF_CTRL_LO : `SSM_OFF_CTRL_HI;
      set_mv(s, dip[s]);
      repeat (6) @(posedge ref_clk);
      cb(irq, 1'b1, "mon irq");
      cb(por, 1'b0, "mon no por");
      bus(1'b1, `SSM_OFF_FLAGS, 32'h22);
      rdr(`SSM_OFF_FLAGS, 32'h2 << (4 * s), 32'h2 << (4 * s), "mon flag");
      set_mv(s, nom[s]);
      repeat (6) @(posedge ref_clk);
      rdr(`SSM_OFF_FLAGS, 32'h4 << (4 * s), 32'h4 << (4 * s), "level reached");
      bus(1'b1, `SSM_OFF_FLAGS, 32'hFF);
      repeat (4) @(posedge ref_clk);
      cb(irq, 1'b0, "irq cleared");
      bus(1'b1, co, 32'h883);
      set_mv(s, dip[s]);
      repeat (6) @(posedge ref_clk);
      rdr(`SSM_OFF_FLAGS, 32'h2 << (4 * s), 32'h0, "masked event");
      cb(irq, 1'b0, "masked irq");
      set_mv(s, nom[s]);
      bus(1'b1, co, 32'h093);
      rdr(`SSM_OFF_STATUS, 32'h1 << s, 32'h1 << s, "delay busy");
      repeat (105) @(posedge ref_clk);
      rdr(`SSM_OFF_STATUS, 32'h1 << s, 32'h0, "delay done");
      rdr(`SSM_OFF_FLAGS, 32'h8 << (4 * s), 32'h8 << (4 * s), "delay flag");
      cb(irq, 1'b1, "delay irq");
      bus(1'b1, co, 32'h083);
      repeat (105) @(posedge ref_clk);
      sleep <= 1'b1;
      bus(1'b1, `SSM_OFF_FLAGS, 32'hFF);
      set_mv(s, low[s]);
      repeat (8) @(posedge ref_clk);
      cb(por, 1'b1, "sup por");
      rdr(`SSM_OFF_FLAGS, 32'h1 << (4 * s), 32'h0, "sleep flag");
      sleep <= 1'b0;
      set_mv(s, dip[s]);
      repeat (8) @(posedge ref_clk);
      cb(por, 1'b1, "hysteresis");
      rdr(`SSM_OFF_FLAGS, 32'h1 << (4 * s), 32'h1 << (4 * s), "sup flag");
      set_mv(s, nom[s]);
      repeat (8) @(posedge ref_clk);
      cb(por, 1'b0, "sup release");
      bus(1'b1, `SSM_OFF_FLAGS, 32'hFF);
    end
    // disabled high supervisor blocks rtc writes and resets nothing
    bus(1'b1, `SSM_OFF_CTRL_HI, 32'h082);
    @(posedge ref_clk);
    cb(rtc_blk, 1'b1, "rtc block");
    repeat (105) @(posedge ref_clk);
    set_mv(0, low[0]);
    repeat (8) @(posedge ref_clk);
    cb(por, 1'b0, "disabled sup");
    set_mv(0, nom[0]);
    bus(1'b1, `SSM_OFF_CTRL_HI, 32'h083);
    @(posedge ref_clk);
    cb(rtc_blk, 1'b0, "rtc open");
    // monitor resets: under the level without overvoltage, over the safe limit with it
    bus(1'b1, `SSM_OFF_CORE, 32'h3);
    bus(1'b1, `SSM_OFF_CTRL_HI, 32'h1B3);
    repeat (105) @(posedge ref_clk);
    set_mv(0, dip[0]);
    repeat (8) @(posedge ref_clk);
    cb(por, 1'b1, "mon por");
    set_mv(0, nom[0]);
    repeat (8) @(posedge ref_clk);
    cb(por, 1'b0, "mon por release");
    bus(1'b1, `SSM_OFF_CTRL_HI, 32'h3B3);
    set_mv(0, 16'h0E74);
    repeat (8) @(posedge ref_clk);
    cb(por, 1'b1, "hi over por");
    // overvoltage on the high side counts only at the top core level
    bus(1'b1, `SSM_OFF_CORE, 32'h2);
    repeat (4) @(posedge ref_clk);
    cb(por, 1'b0, "hi over core");
    set_mv(0, nom[0]);
    bus(1'b1, `SSM_OFF_CTRL_LO, 32'h383);
    set_mv(1, 16'h06A4);
    repeat (8) @(posedge ref_clk);
    cb(por, 1'b1, "lo over por");
    set_mv(1, nom[1]);
    // random code combinations from software
    for (int i = 0; i < 8; i++) begin
      c = 2'($urandom);
      a = 2'($urandom);
      r = 3'($urandom);
      bad = r < {1'b0, a} || r < {1'b0, c} || (c != 2'h3 && r > {1'b0, c} + 3'h3);
      bus(1'b1, `SSM_OFF_CORE, {30'h0, c});
      bus(1'b1, `SSM_OFF_CTRL_HI, {24'h0, 1'b1, r, a, 2'h3});
      rdr(`SSM_OFF_STATUS, 32'h4, {29'h0, bad, 2'h0}, "illegal code");
      cb(illegal, bad, "illegal pin");
    end
    repeat (4) @(posedge ref_clk);
    complete_run();
  end
endmodule
